// ---- atx_pwr_pkg.sv ----
package atx_pwr_pkg;
   localparam int CLK_HZ          = 10_000_000;
   localparam int TICK_HZ         = 32;
   localparam int TICK_CYCLES_DEF = CLK_HZ / TICK_HZ;
   localparam int HOLD_LONG_MS    = 4000;
   localparam int HOLD_SHORT_MS   = 250;
   localparam int RESET_PULSE_MS  = 1000;
   localparam int EXTEND_MS       = 5000;
   localparam logic [7:0] HOLD_LONG_TICKS =
      8'(HOLD_LONG_MS * TICK_HZ / 1000);
   localparam logic [7:0] HOLD_SHORT_TICKS =
      8'(HOLD_SHORT_MS * TICK_HZ / 1000);
   localparam logic [7:0] RESET_PULSE_TICKS =
      8'(RESET_PULSE_MS * TICK_HZ / 1000);
   localparam logic [7:0] EXTEND_TICKS = 8'(EXTEND_MS * TICK_HZ / 1000);
   localparam logic [4:0] SUB_MAX = 5'(TICK_HZ - 1);
   localparam logic [7:0] PLEN_HOLD = 8'hFF;
   localparam logic [7:0] PLEN_DEF  = 8'h20;
   localparam logic [7:0] KEY_SAT   = 8'hFF;
   // Function byte fields.
   localparam int FN_AUTO  = 0;
   localparam int FN_RINV  = 1;
   localparam int FN_PINV  = 2;
   localparam int FN_BLANK = 4;
   localparam int FN_KRST  = 5;
   localparam int FN_KPON  = 6;
   localparam int FN_KPOFF = 7;
   localparam logic [7:0] FUNC_RST = 8'h00;
   localparam logic [7:0] FAN_MASK = 8'h0F;
   // Acknowledge types.
   localparam logic [7:0] ACK_NONE = 8'h00;
   localparam logic [7:0] ACK_FAN  = 8'h5B;
   localparam logic [7:0] ACK_FUNC = 8'h5C;
   localparam logic [7:0] ACK_WDOG = 8'h5D;
   localparam logic [7:0] ACK_STAT = 8'h5E;
   // Register map.
   localparam logic [5:0] A_FUNC  = 6'h00;
   localparam logic [5:0] A_PLEN  = 6'h01;
   localparam logic [5:0] A_WDOG  = 6'h02;
   localparam logic [5:0] A_ACK   = 6'h03;
   localparam logic [5:0] A_STATE = 6'h04;
   localparam logic [5:0] A_FAN   = 6'h08;
   localparam logic [5:0] A_STAT  = 6'h10;
   localparam int FAN_BYTES  = 5;
   localparam int STAT_BYTES = 15;
   // Pin synchroniser lanes.
   localparam int P_SENSE = 0;
   localparam int P_OK    = 1;
   localparam int P_CAN   = 2;
   localparam int P_RST   = 3;
   localparam int P_PWR   = 4;
   localparam int N_PINS  = 5;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic [31:0] power;
      logic [7:0]  failsafe;
   } fan_info_t;

   typedef struct packed {
      logic [7:0]  fan_report;
      logic [31:0] temp_report;
      logic [7:0]  key_press;
      logic [7:0]  key_release;
      logic [31:0] glitch;
      logic [7:0]  contrast;
      logic [7:0]  backlight;
   } status_ext_t;
endpackage

// ---- atx_power_watchdog_control.sv ----
`timescale 1ns/1ps
module atx_power_watchdog_control #(
   parameter int TICK_CYCLES = atx_pwr_pkg::TICK_CYCLES_DEF
) (
   input  wire logic                   sys_clk,
   input  wire logic                   rst_b,
   input  wire atx_pwr_pkg::bus_req_t  bus,
   output logic [7:0]                  rd_data,
   input  wire logic                   sense_pin,
   input  wire logic                   key_confirm_pin,
   input  wire logic                   key_cancel_pin,
   input  wire logic                   reset_line_in,
   output logic                        reset_line_out,
   output logic                        reset_line_oe_b,
   input  wire logic                   power_line_in,
   output logic                        power_line_out,
   output logic                        power_line_oe_b,
   output logic                        display_blank,
   output logic                        backlight_off,
   output logic                        self_restart,
   output logic                        cmd_lockout,
   input  wire atx_pwr_pkg::fan_info_t   fan_info,
   input  wire atx_pwr_pkg::status_ext_t status_ext
);
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   typedef enum logic [1:0] {
      ST_IDLE, ST_RESET, ST_POWER, ST_RESTART
   } state_t;

   // --------------------------------------------------------------
   // Pin synchronisers and tick
   // --------------------------------------------------------------
   logic [4:0]    sync1_reg;
   logic [4:0]    sync2_reg;
   logic          sense_d_reg;
   logic [TW-1:0] tick_cnt_reg;
   logic          tick_reg;

   wire [4:0] pin_vec   = {power_line_in, reset_line_in, key_cancel_pin,
                           key_confirm_pin, sense_pin};

   genvar g;
   generate
      for (g = 0; g < atx_pwr_pkg::N_PINS; g++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            sync1_reg[g] <= rst_b ? pin_vec[g] : 1'b0;
            sync2_reg[g] <= rst_b ? sync1_reg[g] : 1'b0;
         end
      end
   endgenerate

   wire       sense     = sync2_reg[atx_pwr_pkg::P_SENSE];
   wire       key_ok    = sync2_reg[atx_pwr_pkg::P_OK];
   wire       key_can   = sync2_reg[atx_pwr_pkg::P_CAN];
   wire       host_up   = sense & ~sense_d_reg;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
         sense_d_reg  <= 1'b0;
      end else begin
         tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? '0 :
                         TW'(tick_cnt_reg + 1'b1);
         tick_reg     <= (tick_cnt_reg == TICK_LAST);
         sense_d_reg  <= sense;
      end
   end

   // --------------------------------------------------------------
   // Configuration and command writes
   // --------------------------------------------------------------
   state_t     state_reg, state_next;
   logic [7:0] func_reg;
   logic [7:0] plen_reg;
   logic [7:0] ack_reg;
   logic [7:0] wd_cnt_reg;
   logic [4:0] wd_sub_reg;
   logic       lock_reg, lock_next;

   // Writes during a keypad or power-on restart are dropped on purpose.
   wire wr_ok    = bus.wr & ~lock_reg;
   wire wr_func  = wr_ok & (bus.addr == atx_pwr_pkg::A_FUNC);
   wire wr_plen  = wr_ok & (bus.addr == atx_pwr_pkg::A_PLEN);
   wire wr_wdog  = wr_ok & (bus.addr == atx_pwr_pkg::A_WDOG);
   wire rd_fan   = bus.rd & (bus.addr >= atx_pwr_pkg::A_FAN) &
                   (bus.addr < atx_pwr_pkg::A_FAN + 6'(5));
   wire rd_stat  = bus.rd & (bus.addr >= atx_pwr_pkg::A_STAT) &
                   (bus.addr < atx_pwr_pkg::A_STAT + 6'(15));
   wire restart  = (state_reg == ST_RESTART);

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         func_reg <= atx_pwr_pkg::FUNC_RST;
         plen_reg <= atx_pwr_pkg::PLEN_DEF;
         ack_reg  <= atx_pwr_pkg::ACK_NONE;
      end else begin
         if (wr_func) begin
            func_reg <= bus.wdata;
            plen_reg <= atx_pwr_pkg::PLEN_DEF;
         end else if (wr_plen) begin
            plen_reg <= bus.wdata;
         end
         if (wr_func | wr_plen) begin
            ack_reg <= atx_pwr_pkg::ACK_FUNC;
         end else if (wr_wdog) begin
            ack_reg <= atx_pwr_pkg::ACK_WDOG;
         end else if (rd_fan) begin
            ack_reg <= atx_pwr_pkg::ACK_FAN;
         end else if (rd_stat) begin
            ack_reg <= atx_pwr_pkg::ACK_STAT;
         end
      end
   end

   // --------------------------------------------------------------
   // Watchdog
   // --------------------------------------------------------------
   wire wd_sec    = tick_reg & (wd_sub_reg == atx_pwr_pkg::SUB_MAX);
   wire wd_expire = wd_sec & (wd_cnt_reg == 8'h01) & ~wr_wdog;

   always_ff @(posedge sys_clk) begin
      if (!rst_b || restart) begin
         wd_cnt_reg <= 8'h00;
         wd_sub_reg <= 5'h00;
      end else if (wr_wdog) begin
         wd_cnt_reg <= bus.wdata;
         wd_sub_reg <= 5'h00;
      end else if (tick_reg) begin
         wd_sub_reg <= 5'(wd_sub_reg + 1'b1);
         if (wd_sec && wd_cnt_reg != 8'h00) begin
            wd_cnt_reg <= 8'(wd_cnt_reg - 1'b1);
         end
      end
   end

   // --------------------------------------------------------------
   // Key hold timers
   // --------------------------------------------------------------
   logic [7:0] ok_cnt_reg;
   logic [7:0] can_cnt_reg;

   always_ff @(posedge sys_clk) begin
      if (!rst_b || !key_ok) begin
         ok_cnt_reg <= 8'h00;
      end else if (tick_reg && ok_cnt_reg != atx_pwr_pkg::KEY_SAT) begin
         ok_cnt_reg <= 8'(ok_cnt_reg + 1'b1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b || !key_can) begin
         can_cnt_reg <= 8'h00;
      end else if (tick_reg && can_cnt_reg != atx_pwr_pkg::KEY_SAT) begin
         can_cnt_reg <= 8'(can_cnt_reg + 1'b1);
      end
   end

   wire ok_long  = tick_reg & key_ok &
                   (ok_cnt_reg == atx_pwr_pkg::HOLD_LONG_TICKS - 8'h01);
   wire ok_short = tick_reg & key_ok &
                   (ok_cnt_reg == atx_pwr_pkg::HOLD_SHORT_TICKS - 8'h01);
   wire can_long = tick_reg & key_can &
                   (can_cnt_reg == atx_pwr_pkg::HOLD_LONG_TICKS - 8'h01);
   wire fire_rst = ok_long & sense & func_reg[atx_pwr_pkg::FN_KRST];
   wire fire_pon = ok_short & ~sense &
                   func_reg[atx_pwr_pkg::FN_KPON];
   wire fire_pof = can_long & sense &
                   func_reg[atx_pwr_pkg::FN_KPOFF];

   // --------------------------------------------------------------
   // Pulse sequencer
   // --------------------------------------------------------------
   logic [7:0] pulse_reg, pulse_next;
   logic [7:0] ext_reg, ext_next;
   logic       hold_reg, hold_next;
   logic       again_reg, again_next;
   logic       start_sense_reg, start_sense_next;
   logic       rst_out_reg, rst_out_next;
   logic       rst_oe_b_reg, rst_oe_b_next;
   logic       pwr_out_reg, pwr_out_next;
   logic       pwr_oe_b_reg, pwr_oe_b_next;
   logic       blank_reg;
   logic       restart_reg;
   logic [7:0] rd_reg;

   // Auto polarity drives against the level the line rests at.
   wire rst_level = func_reg[atx_pwr_pkg::FN_AUTO] ?
                    ~sync2_reg[atx_pwr_pkg::P_RST] :
                    func_reg[atx_pwr_pkg::FN_RINV];
   wire pwr_level = func_reg[atx_pwr_pkg::FN_AUTO] ?
                    ~sync2_reg[atx_pwr_pkg::P_PWR] :
                    func_reg[atx_pwr_pkg::FN_PINV];
   wire pulse_last = tick_reg & (pulse_reg <= 8'h01);

   always_comb begin
      state_next       = state_reg;
      pulse_next       = pulse_reg;
      ext_next         = ext_reg;
      hold_next        = hold_reg;
      again_next       = again_reg;
      start_sense_next = start_sense_reg;
      rst_out_next     = rst_out_reg;
      rst_oe_b_next    = rst_oe_b_reg;
      pwr_out_next     = pwr_out_reg;
      pwr_oe_b_next    = pwr_oe_b_reg;
      unique case (state_reg)
         ST_IDLE: begin
            rst_oe_b_next = 1'b1;
            pwr_oe_b_next = 1'b1;
            if (fire_rst || wd_expire) begin
               state_next    = ST_RESET;
               pulse_next    = atx_pwr_pkg::RESET_PULSE_TICKS;
               again_next    = fire_rst;
               rst_out_next  = rst_level;
               rst_oe_b_next = 1'b0;
            end else if (fire_pon || fire_pof) begin
               state_next       = ST_POWER;
               pulse_next       = plen_reg;
               hold_next        = (plen_reg == atx_pwr_pkg::PLEN_HOLD);
               ext_next         = 8'h00;
               again_next       = fire_pon;
               start_sense_next = sense;
               pwr_out_next     = pwr_level;
               pwr_oe_b_next    = 1'b0;
            end else if (host_up && func_reg[atx_pwr_pkg::FN_BLANK]) begin
               state_next = ST_RESTART;
               again_next = 1'b1;
            end
         end
         ST_RESET: begin
            if (pulse_last) begin
               rst_oe_b_next = 1'b1;
               state_next    = again_reg ? ST_RESTART : ST_IDLE;
            end else if (tick_reg) begin
               pulse_next = 8'(pulse_reg - 1'b1);
            end
         end
         ST_POWER: begin
            if (hold_reg) begin
               if (sense != start_sense_reg) begin
                  pwr_oe_b_next = 1'b1;
                  state_next    = again_reg ? ST_RESTART : ST_IDLE;
               end
            end else if (pulse_last) begin
               if (!again_reg && key_can &&
                   ext_reg != atx_pwr_pkg::EXTEND_TICKS) begin
                  ext_next = 8'(ext_reg + 1'b1);
               end else begin
                  pwr_oe_b_next = 1'b1;
                  state_next    = again_reg ? ST_RESTART : ST_IDLE;
               end
            end else if (tick_reg) begin
               pulse_next = 8'(pulse_reg - 1'b1);
            end
         end
         ST_RESTART: begin
            state_next = ST_IDLE;
            again_next = 1'b0;
         end
      endcase
      lock_next = (state_next != ST_IDLE) & again_next;
   end

   // --------------------------------------------------------------
   // Readback
   // --------------------------------------------------------------
   function automatic logic [7:0] byte_of(input logic [31:0] w,
                                          input logic [1:0]  i);
      byte_of = w[8*i +: 8];
   endfunction

   wire [3:0]   fan_idx  = 4'(bus.addr - atx_pwr_pkg::A_FAN);
   wire [3:0]   stat_idx = 4'(bus.addr - atx_pwr_pkg::A_STAT);
   wire [7:0]   fs_mask  = fan_info.failsafe &
                           atx_pwr_pkg::FAN_MASK;
   wire [119:0] stat_vec = {status_ext.fan_report,
                            status_ext.temp_report,
                            status_ext.key_press, status_ext.key_release,
                            func_reg, wd_cnt_reg,
                            status_ext.glitch,
                            status_ext.contrast, status_ext.backlight};
   wire [7:0]   fan_byte = (fan_idx == 4'h4) ? fs_mask :
                           byte_of(fan_info.power, 2'(3 - fan_idx));
   wire [7:0]   stat_byte = stat_vec[8*(14 - stat_idx) +: 8];
   wire [7:0]   state_byte = {3'h0, lock_reg, blank_reg, sense,
                              ~pwr_oe_b_reg, ~rst_oe_b_reg};
   wire [7:0]   rd_value =
      rd_fan  ? fan_byte :
      rd_stat ? stat_byte :
      (bus.addr == atx_pwr_pkg::A_FUNC)  ? func_reg :
      (bus.addr == atx_pwr_pkg::A_PLEN)  ? plen_reg :
      (bus.addr == atx_pwr_pkg::A_WDOG)  ? wd_cnt_reg :
      (bus.addr == atx_pwr_pkg::A_ACK)   ? ack_reg :
      (bus.addr == atx_pwr_pkg::A_STATE) ? state_byte : 8'h00;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_reg       <= ST_IDLE;
         pulse_reg       <= 8'h00;
         ext_reg         <= 8'h00;
         hold_reg        <= 1'b0;
         again_reg       <= 1'b0;
         start_sense_reg <= 1'b0;
         rst_out_reg     <= 1'b0;
         rst_oe_b_reg    <= 1'b1;
         pwr_out_reg     <= 1'b0;
         pwr_oe_b_reg    <= 1'b1;
         lock_reg        <= 1'b0;
         blank_reg       <= 1'b0;
         restart_reg     <= 1'b0;
         rd_reg          <= 8'h00;
      end else begin
         state_reg       <= state_next;
         pulse_reg       <= pulse_next;
         ext_reg         <= ext_next;
         hold_reg        <= hold_next;
         again_reg       <= again_next;
         start_sense_reg <= start_sense_next;
         rst_out_reg     <= rst_out_next;
         rst_oe_b_reg    <= rst_oe_b_next;
         pwr_out_reg     <= pwr_out_next;
         pwr_oe_b_reg    <= pwr_oe_b_next;
         lock_reg        <= lock_next;
         blank_reg       <= func_reg[atx_pwr_pkg::FN_BLANK] & ~sense;
         restart_reg     <= restart;
         rd_reg          <= bus.rd ? rd_value : 8'h00;
      end
   end

   assign rd_data         = rd_reg;
   assign reset_line_out  = rst_out_reg;
   assign reset_line_oe_b = rst_oe_b_reg;
   assign power_line_out  = pwr_out_reg;
   assign power_line_oe_b = pwr_oe_b_reg;
   assign display_blank   = blank_reg;
   assign backlight_off   = blank_reg;
   assign self_restart    = restart_reg;
   assign cmd_lockout     = lock_reg;

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_restart_go;
      state_reg == ST_RESTART ##1 self_restart;
   endsequence

   AST_IDLE_HIZ: assert property (
      state_reg == ST_IDLE && $past(state_reg) == ST_IDLE
      |-> reset_line_oe_b && power_line_oe_b)
      else $error("Line driven while idle.");
   AST_KEY_RESET: assert property (
      fire_rst && state_reg == ST_IDLE
      |=> !reset_line_oe_b && pulse_reg == 8'h20 && cmd_lockout)
      else $error("Keypad reset pulse not started.");
   AST_LOCK_DROP: assert property (
      cmd_lockout && bus.wr |=> $stable(func_reg) && $stable(wd_cnt_reg))
      else $error("Write taken during lockout.");
   AST_BLANK: assert property (
      func_reg[4] && !sense |=> display_blank && backlight_off)
      else $error("Display not blanked with host off.");
   AST_HOST_UP: assert property (
      host_up && func_reg[4] && state_reg == ST_IDLE
      && !fire_rst && !wd_expire && !fire_pon && !fire_pof
      |=> s_restart_go)
      else $error("No restart on host power up.");
   AST_WD_OFF: assert property (
      wr_wdog && bus.wdata == 8'h00 |=> wd_cnt_reg == 8'h00 [*2])
      else $error("Watchdog not disabled.");
   AST_WD_FIRE: assert property (
      wd_expire && state_reg == ST_IDLE && !fire_rst
      |=> !reset_line_oe_b && wd_cnt_reg == 8'h00 && !cmd_lockout)
      else $error("Watchdog expiry without reset pulse.");
   AST_HOLD_CLR: assert property (
      !key_ok |=> ok_cnt_reg == 8'h00)
      else $error("Hold timer kept count after release.");
   AST_POLARITY: assert property (
      $fell(power_line_oe_b) && !$past(func_reg[0])
      |-> power_line_out == $past(func_reg[2]))
      else $error("Power pulse polarity wrong.");
endmodule

// ---- atx_host_board_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Motherboard side of the sense, power and reset lines
// ---------------------------------------------------------------
// The board pulls both control lines up, so a released line reads high.
module atx_host_board_model (
   input  wire logic host_on,
   input  wire logic reset_line_out,
   input  wire logic reset_line_oe_b,
   input  wire logic power_line_out,
   input  wire logic power_line_oe_b,
   output logic      sense_pin,
   output logic      reset_line_in,
   output logic      power_line_in
);
   assign sense_pin     = host_on;
   assign reset_line_in = reset_line_oe_b ? 1'b1 : reset_line_out;
   assign power_line_in = power_line_oe_b ? 1'b1 : power_line_out;
endmodule

// ---- atx_power_watchdog_control_bench.sv ----
`timescale 1ns/1ps
module atx_power_watchdog_control_bench;
   localparam int TC = 8;
   logic                     sys_clk, rst_b, host_on, sense_pin;
   logic                     key_confirm_pin, key_cancel_pin;
   logic                     reset_line_in, reset_line_out, reset_line_oe_b;
   logic                     power_line_in, power_line_out, power_line_oe_b;
   logic                     display_blank, backlight_off;
   logic                     self_restart, cmd_lockout;
   logic [7:0]               rd_data;
   atx_pwr_pkg::bus_req_t    bus;
   atx_pwr_pkg::fan_info_t   fan_info;
   atx_pwr_pkg::status_ext_t status_ext;
   int                       fail_count, check_count, cyc_cnt, n;
   // ---------------------------------------------------------------
   // Design and board
   // ---------------------------------------------------------------
   atx_power_watchdog_control #(.TICK_CYCLES(TC)) u_atx_power_watchdog_control (
      .sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rd_data(rd_data),
      .sense_pin(sense_pin), .key_confirm_pin(key_confirm_pin),
      .key_cancel_pin(key_cancel_pin), .reset_line_in(reset_line_in),
      .reset_line_out(reset_line_out), .reset_line_oe_b(reset_line_oe_b),
      .power_line_in(power_line_in), .power_line_out(power_line_out),
      .power_line_oe_b(power_line_oe_b), .display_blank(display_blank),
      .backlight_off(backlight_off), .self_restart(self_restart),
      .cmd_lockout(cmd_lockout), .fan_info(fan_info),
      .status_ext(status_ext));
   atx_host_board_model u_atx_host_board_model (
      .host_on(host_on), .reset_line_out(reset_line_out),
      .reset_line_oe_b(reset_line_oe_b), .power_line_out(power_line_out),
      .power_line_oe_b(power_line_oe_b), .sense_pin(sense_pin),
      .reset_line_in(reset_line_in), .power_line_in(power_line_in));
   // ---------------------------------------------------------------
   // Clock, hang guard and shared tasks
   // ---------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task stop_test;
      $display("Counts: %0d checks, %0d mismatches", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // The whole run needs roughly 8000 cycles.
   always @(posedge sys_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 40000) begin
         fail_count++;
         $display("Error run_time expected finish seen hang");
         stop_test;
      end
   end
   function automatic logic sig(int w);
      case (w)
         0: return reset_line_oe_b;
         1: return power_line_oe_b;
         default: return self_restart;
      endcase
   endfunction
   task chk(string nm, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task in_range(string nm, int k, int lo, int hi);
      check_count++;
      if (k < lo || k > hi) begin
         fail_count++;
         $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, k);
      end
   endtask
   task wr(logic [5:0] a, logic [7:0] v);
      @(posedge sys_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge sys_clk);
      bus <= '0;
   endtask
   task rd(logic [5:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      bus <= '0;
      #1 v = rd_data;
   endtask
   task rdchk(string nm, logic [5:0] a, logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk(nm, e, v);
   endtask
   task wait_for(int w, logic lvl, int maxc, output int k);
      k = 0;
      while (sig(w) !== lvl && k < maxc) begin
         @(posedge sys_clk);
         #1 k++;
      end
      in_range("wait", k, 0, maxc - 1);
   endtask
   task stay(int w, logic lvl, int k);
      int bad;
      bad = 0;
      repeat (k) begin
         @(posedge sys_clk);
         #1 if (sig(w) !== lvl) bad++;
      end
      in_range("stay", bad, 0, 0);
   endtask
   // Pins by number: 0 host power, 1 confirm key, 2 cancel key.
   task set_in(int w, logic v);
      @(posedge sys_clk);
      case (w)
         0: host_on <= v;
         1: key_confirm_pin <= v;
         default: key_cancel_pin <= v;
      endcase
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_reset;
      rdchk("func", atx_pwr_pkg::A_FUNC, 8'h00);
      rdchk("plen", atx_pwr_pkg::A_PLEN, 8'h20);
      rdchk("wdog", atx_pwr_pkg::A_WDOG, 8'h00);
      chk("rst_oe_b", 8'h01, {7'h00, reset_line_oe_b});
      chk("pwr_oe_b", 8'h01, {7'h00, power_line_oe_b});
      rdchk("unmapped", 6'h3F, 8'h00);
      $display("test reset done");
   endtask
   task t_fan;
      fan_info <= '{power: 32'h11223344, failsafe: 8'hF5};
      for (int i = 0; i < 4; i++)
         rdchk("fan", 6'(atx_pwr_pkg::A_FAN + i), 8'(8'h11 * (i + 1)));
      rdchk("failsafe", 6'(atx_pwr_pkg::A_FAN + 4), 8'h05);
      rdchk("ack", atx_pwr_pkg::A_ACK, 8'h5B);
      $display("test fan done");
   endtask
   task t_status;
      logic [7:0] e [15];
      e = '{8'hA1, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hC1, 8'hC2, 8'h20,
            8'h00, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hE1, 8'hE2};
      status_ext <= {8'hA1, 32'hB1B2B3B4, 8'hC1, 8'hC2, 32'hD1D2D3D4,
                     8'hE1, 8'hE2};
      wr(atx_pwr_pkg::A_FUNC, 8'h20);
      rdchk("ack", atx_pwr_pkg::A_ACK, 8'h5C);
      for (int i = 0; i < 15; i++)
         rdchk("status", 6'(atx_pwr_pkg::A_STAT + i), e[i]);
      rdchk("ack", atx_pwr_pkg::A_ACK, 8'h5E);
      $display("test status done");
   endtask
   task t_kreset(logic inv);
      wr(atx_pwr_pkg::A_FUNC, {6'h08, inv, 1'b0});
      set_in(1, 1'b1);
      if (!inv) begin
         repeat (100 * TC) @(posedge sys_clk);
         key_confirm_pin <= 1'b0;
         stay(0, 1'b1, 40 * TC);
         set_in(1, 1'b1);
      end
      wait_for(0, 1'b0, 135 * TC, n);
      in_range("hold", n, 127 * TC, 130 * TC);
      chk("rst_level", {7'h00, inv}, {7'h00, reset_line_out});
      chk("lockout", 8'h01, {7'h00, cmd_lockout});
      wr(atx_pwr_pkg::A_FUNC, 8'h00);
      rdchk("func", atx_pwr_pkg::A_FUNC, {6'h08, inv, 1'b0});
      wait_for(0, 1'b1, 40 * TC, n);
      in_range("rst_len", n, 29 * TC, 33 * TC);
      wait_for(2, 1'b1, 6, n);
      set_in(1, 1'b0);
      $display("test keypad reset done");
   endtask
   task t_power;
      set_in(0, 1'b0);
      wr(atx_pwr_pkg::A_FUNC, 8'h40);
      wr(atx_pwr_pkg::A_PLEN, 8'h04);
      set_in(1, 1'b1);
      wait_for(1, 1'b0, 12 * TC, n);
      in_range("pon_hold", n, 7 * TC, 10 * TC);
      chk("pwr_level", 8'h00, {7'h00, power_line_out});
      set_in(1, 1'b0);
      wait_for(1, 1'b1, 8 * TC, n);
      in_range("pon_len", n, 3 * TC - 2, 5 * TC);
      wait_for(2, 1'b1, 6, n);
      set_in(0, 1'b1);
      wr(atx_pwr_pkg::A_FUNC, 8'h84);
      wr(atx_pwr_pkg::A_PLEN, 8'h02);
      set_in(2, 1'b1);
      wait_for(1, 1'b0, 135 * TC, n);
      in_range("poff_hold", n, 127 * TC, 130 * TC);
      chk("pwr_level", 8'h01, {7'h00, power_line_out});
      repeat (40 * TC) @(posedge sys_clk);
      #1 chk("extend", 8'h00, {7'h00, power_line_oe_b});
      set_in(2, 1'b0);
      wait_for(1, 1'b1, 6 * TC, n);
      $display("test power keys done");
   endtask
   task t_blank;
      wr(atx_pwr_pkg::A_FUNC, 8'h10);
      set_in(0, 1'b0);
      repeat (6) @(posedge sys_clk);
      #1 chk("blank", 8'h01, {7'h00, display_blank});
      chk("backlight", 8'h01, {7'h00, backlight_off});
      set_in(0, 1'b1);
      wait_for(2, 1'b1, 8, n);
      repeat (4) @(posedge sys_clk);
      #1 chk("blank", 8'h00, {7'h00, display_blank});
      $display("test blank done");
   endtask
   task t_wdog;
      logic [7:0] v;
      wr(atx_pwr_pkg::A_FUNC, 8'h00);
      wr(atx_pwr_pkg::A_WDOG, 8'h02);
      rd(atx_pwr_pkg::A_WDOG, v);
      in_range("wd_live", v, 1, 2);
      rd(6'(atx_pwr_pkg::A_STAT + 8), v);
      in_range("wd_status", v, 1, 2);
      repeat (3) begin
         stay(0, 1'b1, 20 * TC);
         wr(atx_pwr_pkg::A_WDOG, 8'h02);
      end
      wr(atx_pwr_pkg::A_WDOG, 8'h00);
      stay(0, 1'b1, 100 * TC);
      wr(atx_pwr_pkg::A_WDOG, 8'h01);
      wait_for(0, 1'b0, 70 * TC, n);
      chk("rst_level", 8'h00, {7'h00, reset_line_out});
      wait_for(0, 1'b1, 40 * TC, n);
      stay(0, 1'b1, 100 * TC);
      rdchk("wdog", atx_pwr_pkg::A_WDOG, 8'h00);
      $display("test watchdog done");
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      bus = '0;
      host_on = 1'b1;
      key_confirm_pin = 1'b0;
      key_cancel_pin = 1'b0;
      fan_info = '0;
      status_ext = '0;
      fail_count = 0;
      check_count = 0;
      cyc_cnt = 0;
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset;
      t_fan;
      t_status;
      t_kreset(1'b0);
      t_kreset(1'b1);
      t_power;
      t_blank;
      t_wdog;
      stop_test;
   end
endmodule
